/* File: flash_array_model.sv */
// ==========================================================
// Flash array stand-in: answers fetches, promptly or slowly
module flash_array_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic slow_in,
   input wire logic flash_req_in,
   input wire logic [14:0] flash_addr_in,
   output logic flash_ack_out,
   output logic [63:0] flash_data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_cnt;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wait_cnt <= 2'h0;
      end else if (flash_req_in && !flash_ack_out) begin
         wait_cnt <= wait_cnt + 2'h1;
      end else begin
         wait_cnt <= 2'h0;
      end
   end

   assign flash_ack_out = flash_req_in && (!slow_in || wait_cnt == 2'h3);

   // Halfword n carries its own address; inverted outside an answer
   always_comb begin
      for (int n = 0; n < 4; n++) begin
         flash_data_out[n*16 +: 16] = flash_ack_out ? {flash_addr_in[14:1], 2'(n)} :
                                      ~{flash_addr_in[14:1], 2'(n)};
      end
   end
endmodule

/* File: flash_ctrl.sv */
// Contract
// - two-word prefetch buffer serves halfword fetches
// - one instance per bank, reads proceed during busy
// - sixteen region bits, 64 pages of 256 bytes
// - region count and page geometry are parameters; only PAGES_PER_REGION acts, lock bits fixed at 16
// - write to locked region aborts, sets lock error
// - lock error interrupts only when enabled
// - lock set and clear commands held nonvolatile
// - wipe pin clears all region bits
// - security bit blocks debug and fast port
// - security bit set only by its command
// - wipe plus full erase clears security
// - two general-purpose bits set and cleared
// - bit 0 enables brownout, wipe clears it
// - bit 1 enables brownout reset, wipe clears
// - eight factory calibration bits, never changed
// - strap pattern selects fast programming mode
// - fast port accepts its command set
// - all straps high 10 s restores boot
// - software sets wait states and timings; program and erase timings are parameters here
// - completion and error status, separate enables
module flash_ctrl #(
   parameter int LOCK_BITS = flash_pkg::LOCK_BITS,
   parameter int PAGES_PER_REGION = flash_pkg::PAGES_PER_REGION,
   parameter int PAGE_BYTES = flash_pkg::PAGE_BYTES,
   parameter int PAGE_PROG_CYC = flash_pkg::PAGE_PROG_CYC,
   parameter int FULL_ERASE_CYC = flash_pkg::FULL_ERASE_CYC,
   parameter logic [15:0] RECOVERY_MS = 16'(flash_pkg::RECOVERY_MS)
) (
   input wire logic clk_in,
   input wire logic rst_in,
   // Bus read port
   input wire logic rd_req_in,
   input wire logic [15:0] rd_addr_in,
   output logic rd_ready_out,
   output logic [15:0] rd_data_out,
   output logic flash_req_out,
   output logic [14:0] flash_addr_out,
   input wire logic flash_ack_in,
   input wire logic [63:0] flash_data_in,
   // Debug and fast port access requests
   input wire logic debug_access_in,
   input wire logic fast_prog_access_in,
   output logic debug_grant_out,
   output logic fast_prog_grant_out,
   // Command port
   input wire logic cmd_valid_in,
   input wire flash_pkg::command_type cmd_in,
   input wire logic cmd_from_fast_port_in,
   output logic cmd_ready_out,
   output logic busy_out,
   output logic [9:0] array_page_out,
   output logic array_prog_out,
   output logic array_erase_out,
   output logic array_full_erase_out,
   // Mode bits
   input wire logic [1:0] wait_states_in,
   input wire logic lock_err_irq_en_in,
   input wire logic done_irq_en_in,
   input wire logic cmd_err_irq_en_in,
   input wire logic status_ack_in,
   output logic lock_error_flag_out,
   output logic cmd_error_flag_out,
   output logic done_flag_out,
   output logic irq_out,
   // Nonvolatile state
   input wire logic wipe_pin_in,
   output logic [15:0] lock_bits_out,
   output logic security_bit_out,
   output logic bod_enable_out,
   output logic bod_reset_enable_out,
   output logic [7:0] cal_bits_out,
   // Straps
   input wire logic test_strap_pin_in,
   input wire logic [2:0] port_line_in,
   output flash_pkg::strap_mode_type strap_mode_out,
   output logic boot_restore_out
);
   // ==========================================================
   // Sequencer state
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_DONE = 2'b11
   } state_type;

   state_type state;
   flash_pkg::cmd_type active_cmd;
   logic [9:0] active_page;
   logic [23:0] timer;
   logic [15:0] lock_bits;
   logic [1:0] gp_bits;
   logic security_bit;
   logic wipe_seen;
   logic [3:0] region;
   logic region_locked;
   logic is_write;
   logic fast_mode;
   logic cmd_take;
   logic cmd_allowed;
   logic lock_err_set;
   logic cmd_err_set;
   logic done_set;

   // ==========================================================
   // Read path, runs beside the sequencer, flushed when a command completes
   prefetch_buffer prefetch_buffer_inst (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .rd_req_in(rd_req_in),
      .rd_addr_in(rd_addr_in),
      .flush_in(done_set),
      .wait_states_in(wait_states_in),
      .rd_ready_out(rd_ready_out),
      .rd_data_out(rd_data_out),
      .flash_req_out(flash_req_out),
      .flash_addr_out(flash_addr_out),
      .flash_ack_in(flash_ack_in),
      .flash_data_in(flash_data_in)
   );

   strap_decoder strap_decoder_inst (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .test_strap_pin_in(test_strap_pin_in),
      .port_line_in(port_line_in),
      .recovery_ms_in(RECOVERY_MS),
      .mode_out(strap_mode_out),
      .recovery_out(boot_restore_out)
   );

   assign fast_mode = strap_mode_out == flash_pkg::MODE_FAST_PROG;

   // ==========================================================
   // Protection checks
   assign region = 4'(cmd_in.page / 10'(PAGES_PER_REGION));
   assign region_locked = lock_bits[region];
   assign is_write = cmd_in.cmd == flash_pkg::CMD_PAGE_PROG
      || cmd_in.cmd == flash_pkg::CMD_PAGE_ERASE;
   assign cmd_ready_out = state == ST_IDLE;
   assign cmd_take = cmd_valid_in && cmd_ready_out;
   // Fast port is shut while secured and outside its strap mode
   assign cmd_allowed = !cmd_from_fast_port_in
      || (fast_mode && !security_bit && cmd_in.cmd != flash_pkg::CMD_GP_SET
          && cmd_in.cmd != flash_pkg::CMD_GP_CLR);
   assign lock_err_set = cmd_take && cmd_allowed && is_write && region_locked;
   assign cmd_err_set = cmd_take && (!cmd_allowed || cmd_in.cmd == flash_pkg::CMD_NOP);
   assign done_set = state == ST_DONE;
   assign debug_grant_out = debug_access_in && !security_bit;
   assign fast_prog_grant_out = fast_prog_access_in && fast_mode && !security_bit;
   assign busy_out = state != ST_IDLE;

   // ==========================================================
   // Command sequencer
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= ST_IDLE;
         active_cmd <= flash_pkg::CMD_NOP;
         active_page <= 10'h0;
         timer <= 24'h0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (cmd_take && cmd_allowed && !lock_err_set
                   && cmd_in.cmd != flash_pkg::CMD_NOP) begin
                  state <= ST_RUN;
                  active_cmd <= cmd_in.cmd;
                  active_page <= cmd_in.page;
                  if (cmd_in.cmd == flash_pkg::CMD_FULL_ERASE) begin
                     timer <= 24'(FULL_ERASE_CYC - 1);
                  end else if (is_write) begin
                     timer <= 24'(PAGE_PROG_CYC - 1);
                  end else begin
                     timer <= 24'h0;
                  end
               end
            end
            ST_RUN: begin
               if (timer == 24'h0) begin
                  state <= ST_DONE;
               end else begin
                  timer <= timer - 24'h1;
               end
            end
            ST_DONE: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         array_page_out <= 10'h0;
         array_prog_out <= 1'b0;
         array_erase_out <= 1'b0;
         array_full_erase_out <= 1'b0;
      end else begin
         array_page_out <= active_page;
         array_prog_out <= state == ST_RUN && active_cmd == flash_pkg::CMD_PAGE_PROG;
         array_erase_out <= state == ST_RUN && active_cmd == flash_pkg::CMD_PAGE_ERASE;
         array_full_erase_out <= state == ST_RUN && active_cmd == flash_pkg::CMD_FULL_ERASE;
      end
   end

   // ==========================================================
   // Nonvolatile bits
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         lock_bits <= flash_pkg::LOCK_RESET;
      end else if (wipe_pin_in) begin
         lock_bits <= '0;
      end else if (done_set && active_cmd == flash_pkg::CMD_LOCK_SET) begin
         lock_bits[4'(active_page / 10'(PAGES_PER_REGION))] <= 1'b1;
      end else if (done_set && active_cmd == flash_pkg::CMD_LOCK_CLR) begin
         lock_bits[4'(active_page / 10'(PAGES_PER_REGION))] <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         gp_bits <= flash_pkg::GP_RESET;
      end else if (wipe_pin_in) begin
         gp_bits <= 2'h0;
      end else if (done_set && active_cmd == flash_pkg::CMD_GP_SET) begin
         gp_bits[active_page[0]] <= 1'b1;
      end else if (done_set && active_cmd == flash_pkg::CMD_GP_CLR) begin
         gp_bits[active_page[0]] <= 1'b0;
      end
   end

   // Wipe must be seen before the full erase ends to lift security
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wipe_seen <= 1'b0;
      end else if (wipe_pin_in) begin
         wipe_seen <= 1'b1;
      end else if (done_set && active_cmd == flash_pkg::CMD_FULL_ERASE) begin
         wipe_seen <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         security_bit <= flash_pkg::SEC_RESET;
      end else if (done_set && active_cmd == flash_pkg::CMD_SEC_SET) begin
         security_bit <= 1'b1;
      end else if (done_set && active_cmd == flash_pkg::CMD_FULL_ERASE && wipe_seen) begin
         security_bit <= 1'b0;
      end
   end

   assign lock_bits_out = lock_bits;
   assign security_bit_out = security_bit;
   assign bod_enable_out = gp_bits[0];
   assign bod_reset_enable_out = gp_bits[1];
   assign cal_bits_out = flash_pkg::CAL_FACTORY;

   // ==========================================================
   // Status flags, set wins over acknowledge
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         lock_error_flag_out <= 1'b0;
         cmd_error_flag_out <= 1'b0;
         done_flag_out <= 1'b0;
      end else begin
         lock_error_flag_out <= lock_err_set || (lock_error_flag_out && !status_ack_in);
         cmd_error_flag_out <= cmd_err_set || (cmd_error_flag_out && !status_ack_in);
         done_flag_out <= done_set || (done_flag_out && !status_ack_in);
      end
   end

   assign irq_out = (lock_error_flag_out && lock_err_irq_en_in)
      || (cmd_error_flag_out && cmd_err_irq_en_in)
      || (done_flag_out && done_irq_en_in);

   // ==========================================================
   // Checks
   lock_abort_a: assert property (@(posedge clk_in) disable iff (rst_in)
      lock_err_set |=> state == ST_IDLE && lock_error_flag_out)
      else $error("locked write not aborted");
   lock_irq_a: assert property (@(posedge clk_in) disable iff (rst_in)
      lock_error_flag_out && !lock_err_irq_en_in && !done_flag_out && !cmd_error_flag_out
      |-> !irq_out)
      else $error("lock irq while disabled");
   wipe_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
      wipe_pin_in |=> lock_bits == '0 && gp_bits == 2'h0)
      else $error("wipe left bits set");
   secure_block_a: assert property (@(posedge clk_in) disable iff (rst_in)
      security_bit |-> !debug_grant_out && !fast_prog_grant_out)
      else $error("access granted while secured");
   sec_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $fell(security_bit) |-> $past(active_cmd) == flash_pkg::CMD_FULL_ERASE)
      else $error("security cleared without erase");
   sec_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(security_bit) |-> $past(active_cmd) == flash_pkg::CMD_SEC_SET)
      else $error("security set by other command");
   flag_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
      done_flag_out && !status_ack_in |=> done_flag_out)
      else $error("done flag dropped");
   cal_fixed_a: assert property (@(posedge clk_in) disable iff (rst_in)
      cal_bits_out == $past(cal_bits_out))
      else $error("calibration changed");
   read_busy_a: assert property (@(posedge clk_in) disable iff (rst_in)
      busy_out && rd_req_in && flash_ack_in ##1 rd_req_in && $stable(rd_addr_in)
      |-> rd_ready_out)
      else $error("read stalled by busy");

   lock_err_c: cover property (@(posedge clk_in) disable iff (rst_in) lock_err_set);
   prog_done_c: cover property (@(posedge clk_in) disable iff (rst_in)
      done_set && active_cmd == flash_pkg::CMD_PAGE_PROG);
   sec_clear_c: cover property (@(posedge clk_in) disable iff (rst_in) $fell(security_bit));
endmodule

/* File: flash_ctrl_test.sv */
module flash_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in, rst_in, rd_req_in, rd_ready_out, flash_req_out, flash_ack_in, slow;
   logic [15:0] rd_addr_in, rd_data_out, lock_bits_out;
   logic [14:0] flash_addr_out;
   logic [63:0] flash_data_in;
   logic debug_access_in, fast_prog_access_in, debug_grant_out, fast_prog_grant_out;
   logic cmd_valid_in, cmd_from_fast_port_in, cmd_ready_out, busy_out, array_prog_out;
   flash_pkg::command_type cmd_in;
   logic [1:0] wait_states_in;
   logic lock_err_irq_en_in, done_irq_en_in, cmd_err_irq_en_in, status_ack_in, wipe_pin_in;
   logic lock_error_flag_out, cmd_error_flag_out, done_flag_out, irq_out;
   logic security_bit_out, bod_enable_out, bod_reset_enable_out, test_strap_pin_in;
   logic [7:0] cal_bits_out;
   logic [2:0] port_line_in;
   flash_pkg::strap_mode_type strap_mode_out;
   logic boot_restore_out, array_erase_out;
   int mismatches, cmp_count, fetches, lat0, lat3, lat, f;
   bit prog_seen, erase_seen;

   flash_ctrl #(.PAGE_PROG_CYC(20), .FULL_ERASE_CYC(20), .RECOVERY_MS(16'h0000)) flash_ctrl_inst (
      .clk_in, .rst_in, .rd_req_in, .rd_addr_in, .rd_ready_out, .rd_data_out, .flash_req_out,
      .flash_addr_out, .flash_ack_in, .flash_data_in, .debug_access_in, .fast_prog_access_in,
      .debug_grant_out, .fast_prog_grant_out, .cmd_valid_in, .cmd_in, .cmd_from_fast_port_in,
      .cmd_ready_out, .busy_out, .array_page_out(), .array_prog_out, .array_erase_out,
      .array_full_erase_out(), .wait_states_in, .lock_err_irq_en_in, .done_irq_en_in,
      .cmd_err_irq_en_in, .status_ack_in, .lock_error_flag_out, .cmd_error_flag_out,
      .done_flag_out, .irq_out, .wipe_pin_in, .lock_bits_out, .security_bit_out,
      .bod_enable_out, .bod_reset_enable_out, .cal_bits_out, .test_strap_pin_in,
      .port_line_in, .strap_mode_out, .boot_restore_out);

   flash_array_model flash_array_model_inst (.clk_in, .rst_in, .slow_in(slow),
      .flash_req_in(flash_req_out), .flash_addr_in(flash_addr_out),
      .flash_ack_out(flash_ack_in), .flash_data_out(flash_data_in));

   // ==========================================================
   // Clock, fetch counter, watchdog
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   always @(negedge clk_in) begin
      if (flash_req_out === 1'b1 && flash_ack_in === 1'b1) fetches++;
      if (array_prog_out === 1'b1) prog_seen = 1'b1;
      if (array_erase_out === 1'b1) erase_seen = 1'b1;
   end

   initial begin
      #100us;
      mismatches++;
      $display("watchdog expired");
      close_out();
   end

   // ==========================================================
   // Tasks
   task close_out;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   function logic [15:0] flags();
      return {13'h0000, lock_error_flag_out, cmd_error_flag_out, done_flag_out};
   endfunction

   task send(input flash_pkg::cmd_type c, input logic [9:0] pg, input logic fast);
      int n;
      n = 0;
      while (cmd_ready_out !== 1'b1 && n < 100) begin
         @(negedge clk_in);
         n++;
      end
      @(posedge clk_in);
      cmd_valid_in <= 1'b1;
      cmd_in <= '{cmd: c, page: pg};
      cmd_from_fast_port_in <= fast;
      @(posedge clk_in);
      cmd_valid_in <= 1'b0;
   endtask

   task wait_flags;
      int n;
      n = 0;
      @(negedge clk_in);
      while (n < 200 && flags() === 16'h0000) begin
         @(negedge clk_in);
         n++;
      end
   endtask

   task run(input flash_pkg::cmd_type c, input logic [9:0] pg, input logic fast);
      send(c, pg, fast);
      wait_flags();
   endtask

   task ack;
      @(posedge clk_in);
      status_ack_in <= 1'b1;
      @(posedge clk_in);
      status_ack_in <= 1'b0;
      @(negedge clk_in);
   endtask

   task rd(input logic [15:0] a, output int lt);
      @(posedge clk_in);
      rd_req_in <= 1'b1;
      rd_addr_in <= a;
      lt = 0;
      @(negedge clk_in);
      while (rd_ready_out !== 1'b1 && lt < 50) begin
         @(negedge clk_in);
         lt++;
      end
      @(posedge clk_in);
      rd_req_in <= 1'b0;
      #1 chk("read data", a, rd_data_out);
   endtask

   task strap(input logic t, input logic [2:0] p, input flash_pkg::strap_mode_type m);
      @(posedge clk_in);
      test_strap_pin_in <= t;
      port_line_in <= p;
      repeat (4) @(negedge clk_in);
      chk("strap mode", 16'(m), 16'(strap_mode_out));
      chk("boot restore", 16'(m == flash_pkg::MODE_RECOVERY), 16'(boot_restore_out));
   endtask

   // ==========================================================
   // Tests
   initial begin
      rst_in = 1'b1;
      {rd_req_in, cmd_valid_in, cmd_from_fast_port_in, status_ack_in, wipe_pin_in} = '0;
      {lock_err_irq_en_in, done_irq_en_in, cmd_err_irq_en_in, slow, test_strap_pin_in} = '0;
      {debug_access_in, fast_prog_access_in} = 2'h3;
      rd_addr_in = 16'h0000;
      cmd_in = '{cmd: flash_pkg::CMD_NOP, page: 10'h000};
      wait_states_in = 2'h0;
      port_line_in = 3'h0;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      @(negedge clk_in);
      chk("lock bits", 16'h0000, lock_bits_out);
      chk("nv bits", 16'h0000, {13'h0, security_bit_out, bod_enable_out, bod_reset_enable_out});
      chk("cal bits", {8'h00, flash_pkg::CAL_FACTORY}, {8'h00, cal_bits_out});
      chk("grants", 16'h0002, {14'h0, debug_grant_out, fast_prog_grant_out});
      $display("test reset done");
      rd(16'h1234, lat0);
      f = fetches;
      rd(16'h1237, lat);
      chk("hit fetches", 16'(f), 16'(fetches));
      wait_states_in <= 2'h3;
      rd(16'h2000, lat3);
      chk("wait delay", 16'(lat0 + 3), 16'(lat3));
      slow <= 1'b1;
      rd(16'h3008, lat);
      slow <= 1'b0;
      wait_states_in <= 2'h0;
      $display("test reads done");
      run(flash_pkg::CMD_LOCK_SET, 10'd64, 1'b0);
      chk("flags", 16'h0001, flags());
      chk("lock bits", 16'h0002, lock_bits_out);
      ack();
      chk("flags", 16'h0000, flags());
      run(flash_pkg::CMD_PAGE_PROG, 10'd127, 1'b0);
      chk("flags", 16'h0004, flags());
      chk("irq", 16'h0000, {15'h0, irq_out});
      chk("prog run", 16'h0000, {15'h0, prog_seen});
      @(posedge clk_in);
      lock_err_irq_en_in <= 1'b1;
      @(negedge clk_in);
      chk("irq", 16'h0001, {15'h0, irq_out});
      ack();
      chk("irq", 16'h0000, {15'h0, irq_out});
      run(flash_pkg::CMD_PAGE_ERASE, 10'd63, 1'b0);
      chk("flags", 16'h0001, flags());
      chk("erase run", 16'h0001, {15'h0, erase_seen});
      ack();
      run(flash_pkg::CMD_LOCK_CLR, 10'd100, 1'b0);
      chk("lock bits", 16'h0000, lock_bits_out);
      ack();
      done_irq_en_in <= 1'b1;
      send(flash_pkg::CMD_PAGE_PROG, 10'd100, 1'b0);
      rd(16'h4444, lat);
      chk("busy", 16'h0001, {15'h0, busy_out});
      wait_flags();
      chk("flags", 16'h0001, flags());
      chk("prog run", 16'h0001, {15'h0, prog_seen});
      chk("irq", 16'h0001, {15'h0, irq_out});
      ack();
      done_irq_en_in <= 1'b0;
      $display("test locks done");
      run(flash_pkg::CMD_GP_SET, 10'd0, 1'b0);
      ack();
      run(flash_pkg::CMD_GP_SET, 10'd1, 1'b0);
      ack();
      chk("gp bits", 16'h0003, {14'h0, bod_enable_out, bod_reset_enable_out});
      run(flash_pkg::CMD_GP_CLR, 10'd0, 1'b0);
      ack();
      chk("gp bits", 16'h0001, {14'h0, bod_enable_out, bod_reset_enable_out});
      strap(1'b1, 3'b011, flash_pkg::MODE_FAST_PROG);
      cmd_err_irq_en_in <= 1'b1;
      run(flash_pkg::CMD_GP_CLR, 10'd1, 1'b1);
      chk("flags", 16'h0002, flags());
      chk("irq", 16'h0001, {15'h0, irq_out});
      chk("gp bits", 16'h0001, {14'h0, bod_enable_out, bod_reset_enable_out});
      ack();
      $display("test gp bits done");
      run(flash_pkg::CMD_SEC_SET, 10'd0, 1'b1);
      chk("flags", 16'h0001, flags());
      chk("security", 16'h0001, {15'h0, security_bit_out});
      chk("grants", 16'h0000, {14'h0, debug_grant_out, fast_prog_grant_out});
      ack();
      run(flash_pkg::CMD_FULL_ERASE, 10'd0, 1'b0);
      chk("security", 16'h0001, {15'h0, security_bit_out});
      ack();
      run(flash_pkg::CMD_LOCK_SET, 10'd960, 1'b0);
      chk("lock bits", 16'h8000, lock_bits_out);
      ack();
      @(posedge clk_in);
      wipe_pin_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      wipe_pin_in <= 1'b0;
      @(negedge clk_in);
      chk("lock bits", 16'h0000, lock_bits_out);
      chk("gp bits", 16'h0000, {14'h0, bod_enable_out, bod_reset_enable_out});
      chk("cal bits", {8'h00, flash_pkg::CAL_FACTORY}, {8'h00, cal_bits_out});
      chk("security", 16'h0001, {15'h0, security_bit_out});
      run(flash_pkg::CMD_FULL_ERASE, 10'd0, 1'b0);
      chk("security", 16'h0000, {15'h0, security_bit_out});
      chk("grants", 16'h0003, {14'h0, debug_grant_out, fast_prog_grant_out});
      ack();
      $display("test security done");
      strap(1'b1, 3'b011, flash_pkg::MODE_FAST_PROG);
      strap(1'b1, 3'b111, flash_pkg::MODE_RECOVERY);
      strap(1'b0, 3'b011, flash_pkg::MODE_NORMAL);
      strap(1'b1, 3'b001, flash_pkg::MODE_NORMAL);
      $display("test straps done");
      close_out();
   end
endmodule

/* File: flash_pkg.sv */
package flash_pkg;
   // ==========================================================
   // Geometry
   localparam int LOCK_BITS = 16;
   localparam int PAGES_PER_REGION = 64;
   localparam int PAGE_BYTES = 256;
   localparam int PAGE_ADDR_W = 10;
   localparam int WORD_ADDR_W = 16;
   localparam int CAL_BITS = 8;
   localparam int GP_BITS = 2;
   localparam int WAIT_W = 2;
   // ==========================================================
   // Reset values
   localparam logic [15:0] LOCK_RESET = 16'h0000;
   localparam logic [1:0] GP_RESET = 2'h0;
   localparam logic SEC_RESET = 1'b0;
   localparam logic [7:0] CAL_FACTORY = 8'h5A; // Arbitrary value
   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int PAGE_PROG_MS = 6;
   localparam int FULL_ERASE_MS = 15;
   localparam int RECOVERY_S = 10;
   localparam int PAGE_PROG_CYC = PAGE_PROG_MS * CLK_MHZ * 1000;
   localparam int FULL_ERASE_CYC = FULL_ERASE_MS * CLK_MHZ * 1000;
   localparam int MS_CYC = CLK_MHZ * 1000;
   localparam int RECOVERY_MS = RECOVERY_S * 1000;
   // ==========================================================
   // Commands
   typedef enum logic [3:0] {
      CMD_NOP = 4'h0,
      CMD_PAGE_PROG = 4'h1,
      CMD_PAGE_ERASE = 4'h2,
      CMD_FULL_ERASE = 4'h3,
      CMD_LOCK_SET = 4'h4,
      CMD_LOCK_CLR = 4'h5,
      CMD_SEC_SET = 4'h6,
      CMD_GP_SET = 4'h7,
      CMD_GP_CLR = 4'h8
   } cmd_type;

   typedef struct packed {
      cmd_type cmd;
      logic [9:0] page;
   } command_type;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_FAST_PROG = 2'h1,
      MODE_RECOVERY = 2'h3
   } strap_mode_type;
endpackage

/* File: prefetch_buffer.sv */
module prefetch_buffer (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic rd_req_in,
   input wire logic [15:0] rd_addr_in,
   input wire logic flush_in,
   input wire logic [1:0] wait_states_in,
   output logic rd_ready_out,
   output logic [15:0] rd_data_out,
   output logic flash_req_out,
   output logic [14:0] flash_addr_out,
   input wire logic flash_ack_in,
   input wire logic [63:0] flash_data_in
);
   // ==========================================================
   // Two 32-bit words held per halfword fetch stream
   logic [63:0] words;
   logic [14:0] tag;
   logic tag_valid;
   logic [1:0] wait_cnt;
   logic hit;

   // Pair covers four halfwords, so bits 1:0 only select within it
   assign hit = tag_valid && tag[14:1] == rd_addr_in[15:2];
   assign flash_req_out = rd_req_in && !hit && wait_cnt == wait_states_in;
   assign flash_addr_out = rd_addr_in[15:1];
   assign rd_ready_out = rd_req_in && hit;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wait_cnt <= 2'h0;
      end else if (rd_req_in && !hit && wait_cnt != wait_states_in) begin
         wait_cnt <= wait_cnt + 2'h1;
      end else if (!flash_req_out || flash_ack_in) begin
         // Count cleared once the array answers or no fetch is out; held while a slow array has not answered yet
         wait_cnt <= 2'h0;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         words <= 64'h0;
         tag <= 15'h0;
         tag_valid <= 1'b0;
      end else if (flush_in) begin
         tag_valid <= 1'b0;
      end else if (flash_req_out && flash_ack_in) begin
         words <= flash_data_in;
         tag <= rd_addr_in[15:1];
         tag_valid <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_data_out <= 16'h0;
      end else if (hit) begin
         rd_data_out <= words[rd_addr_in[1:0] * 16 +: 16];
      end
   end
endmodule

/* File: strap_decoder.sv */
module strap_decoder (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic test_strap_pin_in,
   input wire logic [2:0] port_line_in,
   input wire logic [15:0] recovery_ms_in,
   output flash_pkg::strap_mode_type mode_out,
   output logic recovery_out
);
   // ==========================================================
   // Strap decode and 10 s hold timer
   logic [16:0] cyc;
   logic [15:0] ms;
   logic all_high;

   assign all_high = test_strap_pin_in && (&port_line_in);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mode_out <= flash_pkg::MODE_NORMAL;
      end else if (test_strap_pin_in && port_line_in == 3'h3) begin
         mode_out <= flash_pkg::MODE_FAST_PROG;
      end else if (all_high) begin
         mode_out <= flash_pkg::MODE_RECOVERY;
      end else begin
         mode_out <= flash_pkg::MODE_NORMAL;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cyc <= 17'h0;
         ms <= 16'h0;
         recovery_out <= 1'b0;
      end else if (!all_high) begin
         cyc <= 17'h0;
         ms <= 16'h0;
         recovery_out <= 1'b0;
      end else if (ms == recovery_ms_in) begin
         recovery_out <= 1'b1;
      end else if (cyc == 17'(flash_pkg::MS_CYC - 1)) begin
         cyc <= 17'h0;
         ms <= ms + 16'h1;
      end else begin
         cyc <= cyc + 17'h1;
      end
   end
endmodule
